// >>> hdl/isb_host.sv
// isa host end: apb-driven master that runs i/o and memory cycles
`timescale 1ns/1ps
`default_nettype none
module isb_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq_out,
  isb_if.host bus
);
  import isb_pkg::*;

  // ***********************************************************
  // state
  // ***********************************************************
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_ADR = 3'b001,
    HS_STB = 3'b010,
    HS_WT = 3'b011,
    HS_END = 3'b100
  } isb_hst_t;

  typedef struct packed {
    isb_hst_t st;
    logic [3:0] cnt;
    isb_cmd_t typ;
    logic w16, second, cs16, busy, irq_d;
    logic [15:0] addr, wdat, rdat;
    logic [1:0] istat, imask;
    logic [2:0] hctrl;
    logic [4:0] rcnt;
    logic [15:0] sa, sd_h;
    logic aen, ior_n, iow_n, memr_n, ref_n, sbhe_n, hit_n, sd_h_oe;
    logic isa_reset, pready, pslverr, irq_out;
    logic [31:0] prdata;
  } isb_hreg_t;

  localparam isb_hreg_t HREG_RST = '{
    st: HS_IDLE, cnt: 4'h0, typ: ISB_IORD, w16: 1'b0, second: 1'b0,
    cs16: 1'b0, busy: 1'b0, irq_d: 1'b0, addr: 16'h0000, wdat: 16'h0000,
    rdat: 16'h0000, istat: 2'b00, imask: 2'b00, hctrl: 3'b000,
    rcnt: 5'h00, sa: 16'h0000, sd_h: 16'h0000, aen: 1'b1, ior_n: 1'b1,
    iow_n: 1'b1, memr_n: 1'b1, ref_n: 1'b1, sbhe_n: 1'b1, hit_n: 1'b1,
    sd_h_oe: 1'b0, isa_reset: 1'b0, pready: 1'b0, pslverr: 1'b0,
    irq_out: 1'b0, prdata: 32'h00000000
  };

  isb_hreg_t cur;
  isb_hreg_t next_cur;
  logic [18:0] pin_s;
  logic s_rdy, s_cs16_n, s_irq;
  logic [15:0] s_sd;

  isb_sync #(.W(19), .INIT(HPIN_INIT)) u_pin (
    .pclk(pclk),
    .presetn(presetn),
    .d({bus.iochrdy, bus.iocs16_n, bus.irq, bus.sd}),
    .q(pin_s)
  );
  assign {s_rdy, s_cs16_n, s_irq, s_sd} = pin_s;

  // ***********************************************************
  // apb slave, cycle sequencer, reset pulse
  // ***********************************************************
  always_comb begin
    logic [1:0] clr;
    logic [1:0] ev;
    clr = 2'b00;
    ev = 2'b00;
    next_cur = cur;
    next_cur.pready = 1'b0;
    next_cur.pslverr = 1'b0;
    // one wait-free access phase: answer prepared at setup
    if (psel && !penable && !cur.pready) begin
      next_cur.pready = 1'b1;
      case (paddr)
        HR_CMD: next_cur.prdata = {29'h0, cur.w16, cur.typ};
        HR_ADDR: next_cur.prdata = {16'h0000, cur.addr};
        HR_WDAT: next_cur.prdata = {16'h0000, cur.wdat};
        HR_RDAT: next_cur.prdata = {16'h0000, cur.rdat};
        HR_STAT: next_cur.prdata = {29'h0, cur.cs16, s_irq, cur.busy};
        HR_ISTAT: next_cur.prdata = {30'h0, cur.istat};
        HR_IMASK: next_cur.prdata = {30'h0, cur.imask};
        HR_CTRL: next_cur.prdata = {29'h0, cur.hctrl};
        default: begin
          next_cur.prdata = 32'h00000000;
          next_cur.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && cur.pready && pwrite) begin
      case (paddr)
        HR_CMD: begin
          // commands during a cycle or a reset pulse are dropped
          if (!cur.busy && cur.rcnt == 5'h00) begin
            next_cur.typ = isb_cmd_t'(pwdata[1:0]);
            next_cur.w16 = pwdata[CMD_W16];
            next_cur.busy = 1'b1;
            next_cur.second = 1'b0;
            next_cur.cs16 = 1'b0;
            next_cur.sa = cur.addr;
            next_cur.aen = 1'b0;
            next_cur.sbhe_n = ~pwdata[CMD_W16];
            next_cur.hit_n = ~pwdata[1];
            next_cur.sd_h = cur.wdat;
            next_cur.sd_h_oe = (pwdata[1:0] == ISB_IOWR);
            next_cur.st = HS_ADR;
          end
        end
        HR_ADDR: next_cur.addr = pwdata[15:0];
        HR_WDAT: next_cur.wdat = pwdata[15:0];
        HR_IMASK: next_cur.imask = pwdata[1:0];
        HR_CTRL: begin
          next_cur.hctrl = pwdata[2:0];
          if (pwdata[HC_RST]) begin
            next_cur.rcnt = 5'(RESET_CYC);
          end
        end
        default: ;
      endcase
    end else if (psel && penable && cur.pready && paddr == HR_ISTAT) begin
      clr = cur.prdata[1:0];
    end
    case (cur.st)
      HS_IDLE: ;
      HS_ADR: begin
        // address stood one cycle before the strobe
        next_cur.ior_n = (cur.typ != ISB_IORD);
        next_cur.iow_n = (cur.typ != ISB_IOWR);
        next_cur.memr_n = ~cur.typ[1];
        next_cur.ref_n = (cur.typ != ISB_REFRD);
        next_cur.cnt = 4'(SETTLE_CYC);
        next_cur.st = HS_STB;
      end
      HS_STB: begin
        if (!s_cs16_n) begin
          next_cur.cs16 = 1'b1;
        end
        next_cur.cnt = cur.cnt - 4'h1;
        if (cur.cnt == 4'h1) begin
          next_cur.st = HS_WT;
        end
      end
      HS_WT: begin
        // memory cycles carry no ready wait here
        if (cur.typ[1] || s_rdy) begin
          if (cur.second) begin
            next_cur.rdat[15:8] = s_sd[7:0];
          end else if (cur.w16 && cur.cs16) begin
            next_cur.rdat = s_sd;
          end else begin
            next_cur.rdat = {8'h00, s_sd[7:0]};
          end
          next_cur.ior_n = 1'b1;
          next_cur.iow_n = 1'b1;
          next_cur.memr_n = 1'b1;
          next_cur.ref_n = 1'b1;
          next_cur.st = HS_END;
        end
      end
      HS_END: begin
        if (cur.w16 && !cur.cs16 && !cur.second && !cur.typ[1]) begin
          next_cur.second = 1'b1;
          next_cur.sa = cur.addr + 16'h0001;
          next_cur.sbhe_n = 1'b1;
          next_cur.sd_h = {8'h00, cur.wdat[15:8]};
          next_cur.st = HS_ADR;
        end else begin
          next_cur.aen = 1'b1;
          next_cur.sd_h_oe = 1'b0;
          next_cur.hit_n = 1'b1;
          next_cur.sbhe_n = 1'b1;
          next_cur.busy = 1'b0;
          ev[0] = 1'b1;
          next_cur.st = HS_IDLE;
        end
      end
      default: next_cur.st = HS_IDLE;
    endcase
    // device irq rising edge is the second event
    next_cur.irq_d = s_irq;
    ev[1] = s_irq & ~cur.irq_d;
    next_cur.istat = (cur.istat & ~clr) | ev;
    next_cur.irq_out = |(cur.istat & cur.imask);
    if (cur.rcnt != 5'h00) begin
      next_cur.rcnt = cur.rcnt - 5'h01;
    end
    next_cur.isa_reset = (cur.rcnt != 5'h00);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= HREG_RST;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from cur
  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign irq_out = cur.irq_out;
  assign bus.sa = cur.sa;
  assign bus.aen = cur.aen;
  assign bus.ior_n = cur.ior_n;
  assign bus.iow_n = cur.iow_n;
  assign bus.memr_n = cur.memr_n;
  assign bus.ref_n = cur.ref_n;
  assign bus.sbhe_n = cur.sbhe_n;
  assign bus.isa_reset = cur.isa_reset;
  assign bus.boot_rom_hit_n = cur.hit_n;
  assign bus.sd_h = cur.sd_h;
  assign bus.sd_h_oe = cur.sd_h_oe;
  assign bus.ear_oe = cur.hctrl[HC_EAR_OE];
  assign bus.ear_o = cur.hctrl[HC_EAR_LVL];
endmodule : isb_host
`default_nettype wire

// >>> hdl/isb_pkg.sv
// shared constants and types for both ends of the isa slave bus
package isb_pkg;
  // ***********************************************************
  // device i/o window, byte offsets within a 256-byte block
  // ***********************************************************
  localparam logic [7:0] IDP_LAST = 8'h0f;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h11;
  localparam logic [7:0] OFF_CTRL = 8'h12;
  localparam logic [7:0] OFF_WCFG = 8'hf0;
  localparam logic [7:0] WCFG_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [5:0] MASK_RST = 6'h00;
  localparam int WCFG_W16 = 0;
  localparam int CTRL_TP = 0;
  localparam int CTRL_EXTERNAL_ADDRESS_DETECT_MODE = 1;
  localparam int NFLAG = 6;
  // ***********************************************************
  // host apb map
  // ***********************************************************
  localparam logic [7:0] HR_CMD = 8'h00;
  localparam logic [7:0] HR_ADDR = 8'h04;
  localparam logic [7:0] HR_WDAT = 8'h08;
  localparam logic [7:0] HR_RDAT = 8'h0c;
  localparam logic [7:0] HR_STAT = 8'h10;
  localparam logic [7:0] HR_ISTAT = 8'h14;
  localparam logic [7:0] HR_IMASK = 8'h18;
  localparam logic [7:0] HR_CTRL = 8'h1c;
  localparam int CMD_W16 = 2;
  localparam int HC_RST = 0;
  localparam int HC_EAR_OE = 1;
  localparam int HC_EAR_LVL = 2;
  typedef enum logic [1:0] {
    ISB_IORD = 2'b00,
    ISB_IOWR = 2'b01,
    ISB_MEMRD = 2'b10,
    ISB_REFRD = 2'b11
  } isb_cmd_t;
  // ***********************************************************
  // timing, pclk at 40 mhz stands in for the crystal domain
  // ***********************************************************
  localparam int CLK_NS = 25;
  localparam int XTAL_NS = 50;
  localparam int RESET_PERIODS = 10;
  localparam int RESET_CYC = (RESET_PERIODS * XTAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC = 8;
  localparam int DEV_WAIT = 4;
  // synchroniser reset levels: strobes idle high
  localparam logic [24:0] DPIN_INIT = 25'h0ff0000;
  localparam logic [18:0] HPIN_INIT = 19'h60000;
endpackage : isb_pkg

// >>> hdl/isb_if.sv
// pin bundle joining the isa device end and the host end
`timescale 1ns/1ps
`default_nettype none
interface isb_if;
  logic [15:0] sa;
  logic aen, ior_n, iow_n, memr_n, ref_n, sbhe_n, isa_reset;
  logic boot_rom_hit_n;
  logic [15:0] sd_h;
  logic sd_h_oe;
  logic [15:0] sd_d;
  logic [1:0] sd_d_oe;
  logic iochrdy_oe, iocs16_oe, irq, transceiver_disable_o, transceiver_disable_oe, ear_o, ear_oe;
  logic [15:0] sd;
  logic iochrdy, iocs16_n, transceiver_disable;
  // wire levels from the enables; open-drain lines pulled up
  assign sd[7:0] = sd_d_oe[0] ? sd_d[7:0] : (sd_h_oe ? sd_h[7:0] : 8'h00);
  assign sd[15:8] = sd_d_oe[1] ? sd_d[15:8] : (sd_h_oe ? sd_h[15:8] : 8'h00);
  assign iochrdy = ~iochrdy_oe;
  assign iocs16_n = ~iocs16_oe;
  assign transceiver_disable = transceiver_disable_oe ? transceiver_disable_o : (ear_oe ? ear_o : 1'b1);
  modport dev (
    input sa, aen, ior_n, iow_n, memr_n, ref_n, sbhe_n, isa_reset,
    input boot_rom_hit_n, sd, transceiver_disable,
    output sd_d, sd_d_oe, iochrdy_oe, iocs16_oe, irq, transceiver_disable_o, transceiver_disable_oe
  );
  modport host (
    output sa, aen, ior_n, iow_n, memr_n, ref_n, sbhe_n, isa_reset,
    output boot_rom_hit_n, sd_h, sd_h_oe, ear_o, ear_oe,
    input sd, iochrdy, iocs16_n, irq, transceiver_disable
  );
endinterface : isb_if
`default_nettype wire

// >>> hdl/isb_sync.sv
// two-flop synchroniser for pins entering the pclk domain
`timescale 1ns/1ps
`default_nettype none
module isb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  // meta feeds q and nothing else
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : isb_sync
`default_nettype wire

// >>> hdl/isb_dev.sv
// isa slave device end: decode, ready, selects, irq and transceiver_disable pin
`timescale 1ns/1ps
`default_nettype none
module isb_dev #(
  parameter logic [9:0] IO_BASE = 10'h300,
  parameter int WAIT_CYC = isb_pkg::DEV_WAIT
) (
  input wire logic pclk,
  input wire logic presetn,
  isb_if.dev bus,
  input wire logic [isb_pkg::NFLAG-1:0] event_pulse,
  input wire logic [7:0] prom_data,
  input wire logic own_reject,
  input wire logic sleep,
  output logic [15:0] prom_addr,
  output logic id_prom_select_n,
  output logic boot_rom_select_n,
  output logic frame_reject
);
  import isb_pkg::*;

  // ***********************************************************
  // state
  // ***********************************************************
  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_WAIT = 2'b01,
    D_HOLD = 2'b10
  } isb_dst_t;

  typedef struct packed {
    isb_dst_t st;
    logic [3:0] cnt;
    logic [15:0] sd_o;
    logic [1:0] sd_oe;
    logic rdy_oe;
    logic cs16;
    logic irq;
    logic idp_n;
    logic boot_n;
    logic dx_o;
    logic dx_oe;
    logic rej;
    logic [15:0] paddr;
    logic [NFLAG-1:0] stat;
    logic [NFLAG-1:0] mask;
    logic [7:0] ctrl;
    logic [7:0] wcfg;
    logic seen;
    logic sbhe_d;
  } isb_dreg_t;

  localparam isb_dreg_t DREG_RST = '{
    st: D_IDLE, cnt: 4'h0, sd_o: 16'h0000, sd_oe: 2'b00, rdy_oe: 1'b0,
    cs16: 1'b0, irq: 1'b0, idp_n: 1'b1, boot_n: 1'b1, dx_o: 1'b0,
    dx_oe: 1'b0, rej: 1'b0, paddr: 16'h0000, stat: '0, mask: MASK_RST,
    ctrl: CTRL_RST, wcfg: WCFG_RST, seen: 1'b0, sbhe_d: 1'b1
  };

  isb_dreg_t cur;
  isb_dreg_t next_cur;

  // ***********************************************************
  // pin synchronisers
  // ***********************************************************
  logic [24:0] pin_s;
  logic [15:0] sd_s;
  logic s_rst, s_aen, s_ior_n, s_iow_n, s_memr_n, s_ref_n, s_sbhe_n;
  logic s_hit_n, s_dx;
  logic [15:0] s_sa;

  isb_sync #(.W(25), .INIT(DPIN_INIT)) u_pin (
    .pclk(pclk),
    .presetn(presetn),
    .d({bus.isa_reset, bus.aen, bus.ior_n, bus.iow_n, bus.memr_n,
        bus.ref_n, bus.sbhe_n, bus.boot_rom_hit_n, bus.transceiver_disable, bus.sa}),
    .q(pin_s)
  );

  isb_sync #(.W(16), .INIT(16'h0000)) u_sd (
    .pclk(pclk),
    .presetn(presetn),
    .d(bus.sd),
    .q(sd_s)
  );

  assign {s_rst, s_aen, s_ior_n, s_iow_n, s_memr_n, s_ref_n, s_sbhe_n,
          s_hit_n, s_dx, s_sa} = pin_s;

  // ***********************************************************
  // address decode
  // ***********************************************************
  logic [7:0] off;
  logic hit, rd_q, wr_q, idp, boot, cs16, wide;

  // only sa9..sa0 count; the window is 256 bytes at IO_BASE
  assign off = s_sa[7:0];
  assign hit = ~s_aen && (s_sa[9:8] == IO_BASE[9:8]);
  assign rd_q = hit && ~s_ior_n;
  assign wr_q = hit && ~s_iow_n;
  assign idp = off <= IDP_LAST;
  assign boot = ~s_hit_n && ~s_memr_n && s_ref_n;
  // no strobe in this term, so it is valid before ior/iow
  assign cs16 = hit && cur.wcfg[WCFG_W16] && cur.seen && ~idp && ~boot;
  assign wide = cs16 && ~s_sbhe_n && ~off[0];

  // register byte seen at a given offset
  function automatic logic [7:0] reg_byte(
    input logic [7:0] o,
    input isb_dreg_t r
  );
    case (o)
      OFF_STAT: reg_byte = {2'b00, r.stat};
      OFF_MASK: reg_byte = {2'b00, r.mask};
      OFF_CTRL: reg_byte = r.ctrl;
      OFF_WCFG: reg_byte = r.wcfg;
      default: reg_byte = 8'h00;
    endcase
  endfunction : reg_byte

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb begin
    logic [7:0] o;
    logic [NFLAG-1:0] clr;
    o = 8'h00;
    clr = '0;
    next_cur = cur;
    // sbhe stays high on 8-bit-only hosts, so wide stays off
    next_cur.sbhe_d = s_sbhe_n;
    next_cur.seen = cur.seen | (cur.sbhe_d & ~s_sbhe_n);
    next_cur.cs16 = cs16;
    next_cur.idp_n = ~(rd_q && idp);
    next_cur.boot_n = ~boot;
    next_cur.paddr = s_sa;
    next_cur.dx_oe = ~cur.ctrl[CTRL_EXTERNAL_ADDRESS_DETECT_MODE];
    next_cur.dx_o = cur.ctrl[CTRL_TP] | sleep;
    next_cur.rej = own_reject | (cur.ctrl[CTRL_EXTERNAL_ADDRESS_DETECT_MODE] & ~s_dx);
    next_cur.irq = |(cur.stat & ~cur.mask);
    case (cur.st)
      D_IDLE: begin
        next_cur.sd_oe = 2'b00;
        if (rd_q || wr_q) begin
          next_cur.st = D_WAIT;
          next_cur.cnt = 4'(WAIT_CYC);
          next_cur.rdy_oe = 1'b1;
        end
      end
      D_WAIT: begin
        next_cur.cnt = cur.cnt - 4'h1;
        // a strobe dropped early aborts the cycle quietly
        if (!(rd_q || wr_q)) begin
          next_cur.st = D_IDLE;
          next_cur.rdy_oe = 1'b0;
        end else if (cur.cnt == 4'h1) begin
          next_cur.st = D_HOLD;
          next_cur.rdy_oe = 1'b0;
          for (int i = 0; i < 2; i++) begin
            o = off | 8'(i);
            if (i == 0 || wide) begin
              if (rd_q) begin
                next_cur.sd_o[8*i +: 8] = idp ? prom_data : reg_byte(o, cur);
                next_cur.sd_oe[i] = 1'b1;
                if (o == OFF_STAT) begin
                  clr = cur.stat;
                end
              end else begin
                case (o)
                  OFF_MASK: next_cur.mask = sd_s[8*i +: NFLAG];
                  OFF_CTRL: next_cur.ctrl = sd_s[8*i +: 8];
                  OFF_WCFG: next_cur.wcfg = sd_s[8*i +: 8];
                  default: ;
                endcase
              end
            end
          end
        end
      end
      D_HOLD: begin
        // bus stays driven until the host lets go of the strobe
        if (s_ior_n && s_iow_n) begin
          next_cur.st = D_IDLE;
          next_cur.sd_oe = 2'b00;
        end
      end
      default: next_cur.st = D_IDLE;
    endcase
    // boot prom data goes out on the low lane only
    if (boot) begin
      next_cur.sd_o = {8'h00, prom_data};
      next_cur.sd_oe = 2'b01;
    end
    // read clears, but a same-cycle event still sets
    next_cur.stat = (cur.stat & ~clr) | event_pulse;
    if (s_rst) begin
      next_cur = DREG_RST;
    end
  end

  // power-up reset via presetn, pin reset via the comb path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= DREG_RST;
    end else begin
      cur <= next_cur;
    end
  end

  // ***********************************************************
  // outputs, all straight from cur
  // ***********************************************************
  assign bus.sd_d = cur.sd_o;
  assign bus.sd_d_oe = cur.sd_oe;
  assign bus.iochrdy_oe = cur.rdy_oe;
  assign bus.iocs16_oe = cur.cs16;
  assign bus.irq = cur.irq;
  assign bus.transceiver_disable_o = cur.dx_o;
  assign bus.transceiver_disable_oe = cur.dx_oe;
  assign prom_addr = cur.paddr;
  assign id_prom_select_n = cur.idp_n;
  assign boot_rom_select_n = cur.boot_n;
  assign frame_reject = cur.rej;
endmodule : isb_dev
`default_nettype wire

// >>> verif/isb_assertions.sv
// concurrent checks on the pins between the device end and the host end
`timescale 1ns/1ps
`default_nettype none
module isb_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] sa,
  input wire logic aen,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic memr_n,
  input wire logic ref_n,
  input wire logic isa_reset,
  input wire logic [1:0] sd_d_oe,
  input wire logic iochrdy_oe,
  input wire logic iocs16_oe,
  input wire logic irq
);
  // ***********************************************************
  // device side pin rules
  // ***********************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // wait state length is fixed, so the host never sees a short cycle
  a_rdy_wait: assert property (
    $rose(iochrdy_oe) |-> iochrdy_oe [*4] ##1 !iochrdy_oe)
    else $error("ready held for the wrong count");
  a_read_data: assert property (
    $fell(iochrdy_oe) && !ior_n |-> sd_d_oe[0])
    else $error("ready without read data");
  a_write_quiet: assert property (
    $fell(iochrdy_oe) && !iow_n |-> sd_d_oe == 2'b00)
    else $error("data bus driven on a write");
  // the bus is only driven behind a read strobe, three syncing edges late
  a_drive_reads: assert property (
    |sd_d_oe |-> !$past(ior_n, 3) || !$past(memr_n, 3))
    else $error("data bus driven with no read");
  a_wide_decode: assert property (
    iocs16_oe |-> !$past(aen, 3) && $past(sa[7:0], 3) >= 8'h10)
    else $error("wide select outside decode");
  a_reset_idle: assert property (
    isa_reset [*3] |=> !irq && !iochrdy_oe && !iocs16_oe && sd_d_oe == 2'b00)
    else $error("output not idle in reset");
  a_rdy_qual: assert property (
    $rose(iochrdy_oe) |-> (!ior_n || !iow_n) && !$past(aen, 2)
      && $past(sa[9:8], 2) == 2'b11)
    else $error("wait for an unqualified cycle");
  a_refresh_quiet: assert property (
    (!ref_n && ior_n) [*4] |-> sd_d_oe == 2'b00)
    else $error("memory read answered in refresh");
  a_aen_idle: assert property (
    (aen && memr_n) [*5] |-> sd_d_oe == 2'b00 && !iochrdy_oe && !iocs16_oe)
    else $error("device active with aen high");
  c_read_done: cover property ($fell(iochrdy_oe) && !ior_n);
  c_wide: cover property ($rose(iocs16_oe));
  c_irq: cover property ($rose(irq));
endmodule : isb_assertions
`default_nettype wire

// >>> verif/test_isa_slave_bus_interface.sv
// self-checking bench for the device and host ends joined by the pins
`timescale 1ns/1ps
`default_nettype none
module test_isa_slave_bus_interface;
  import isb_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_out, err;
  logic [7:0] paddr, prom_data;
  logic [31:0] pwdata, prdata, r, st;
  logic [5:0] event_pulse;
  logic own_reject, sleep, frame_reject, id_sel_n, boot_sel_n;
  logic [15:0] prom_addr;
  int n_errors, n_tests, m_ctrl, m_mask, m_stat, k_sel;
  int n_idsel = 0;
  int n_bsel = 0;
  int cyc = 0;
  isb_if bus_if ();
  isb_dev isb_dev_inst (.pclk(pclk), .presetn(presetn), .bus(bus_if),
    .event_pulse(event_pulse), .prom_data(prom_data),
    .own_reject(own_reject), .sleep(sleep), .prom_addr(prom_addr),
    .id_prom_select_n(id_sel_n), .boot_rom_select_n(boot_sel_n),
    .frame_reject(frame_reject));
  isb_host isb_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_out(irq_out), .bus(bus_if));
  isb_assertions isb_assertions_inst (.pclk(pclk), .presetn(presetn),
    .sa(bus_if.sa), .aen(bus_if.aen), .ior_n(bus_if.ior_n),
    .iow_n(bus_if.iow_n), .memr_n(bus_if.memr_n), .ref_n(bus_if.ref_n),
    .isa_reset(bus_if.isa_reset), .sd_d_oe(bus_if.sd_d_oe),
    .iochrdy_oe(bus_if.iochrdy_oe), .iocs16_oe(bus_if.iocs16_oe),
    .irq(bus_if.irq));
  // ***********************************************************
  // clock, watchdog and shared tasks
  // ***********************************************************
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // a hang counts as a mismatch; whole run needs under two thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  // select pulses are short, so count the cycles each one is seen low
  always @(posedge pclk) begin
    if (id_sel_n === 1'b0) begin
      n_idsel <= n_idsel + 1;
    end
    if (boot_sel_n === 1'b0) begin
      n_bsel <= n_bsel + 1;
    end
  end
  task automatic end_sim;
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask : tdone
  // leading edge keeps a release and the next setup in separate steps
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one isa cycle by the host end; st keeps status, r the read data
  task automatic io(input int c, input int a, input int d);
    apb(1'b1, HR_ADDR, a);
    apb(1'b1, HR_WDAT, d);
    apb(1'b1, HR_CMD, c);
    do apb(1'b0, HR_STAT, 0); while (r[0] !== 1'b0);
    st = r;
    apb(1'b0, HR_RDAT, 0);
  endtask : io
  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    event_pulse = 6'h00;
    prom_data = 8'h00;
    own_reject = 1'b0;
    sleep = 1'b0;
    n_errors = 0;
    n_tests = 0;
    m_ctrl = 0;
    m_stat = 0;
    void'($urandom(50466));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    io(ISB_IORD, 16'h3f0, 0);
    chk("wcfg", r[7:0], WCFG_RST);
    apb(1'b0, 8'h20, 0);
    chk("perr", err, 1);
    tdone("reset");
    // id prom bytes, plus a read at a foreign base that must stay quiet
    for (int i = 0; i < 16; i += 5) begin
      prom_data <= 8'($urandom);
      io(ISB_IORD, 16'h300 + i, 0);
      chk("idprom", r[7:0], prom_data);
      chk("idwide", st[2], 0);
    end
    chk("idsel", n_idsel != 0, 1);
    k_sel = n_idsel;
    io(ISB_IORD, 16'h20f, 0);
    chk("foreign", r[15:0], 0);
    io(ISB_IOWR, 16'h212, 1);
    tdone("idprom");
    // control byte steers the transceiver pin, sleep forces it high
    for (int k = 0; k < 6; k++) begin
      m_ctrl = k >> 1;
      sleep <= k[0];
      if (k > 0) io(ISB_IOWR, 16'h312, m_ctrl);
      io(ISB_IORD, 16'h312, 0);
      chk("ctrl", r[7:0], m_ctrl);
      chk("transceiver_disable", bus_if.transceiver_disable, m_ctrl[0] | k[0] | m_ctrl[1]);
    end
    for (int e = 0; e < 4; e++) begin
      own_reject <= e[0];
      apb(1'b1, HR_CTRL, {e[1], 2'b10});
      repeat (4) @(posedge pclk);
      chk("reject", frame_reject, e[0] | !e[1]);
    end
    apb(1'b1, HR_CTRL, 0);
    chk("idquiet", n_idsel, k_sel);
    tdone("transceiver_disable");
    for (int w = 0; w < 2; w++) begin
      io(ISB_IOWR, 16'h3f0, w);
      io(4, 16'h312, 0);
      chk("wide", st[2], w);
      chk("wdat", r[15:0], m_ctrl);
    end
    tdone("width");
    // each flag raises irq only while its own mask bit is clear
    apb(1'b1, HR_IMASK, 2);
    for (int i = 0; i < NFLAG; i++) begin
      io(ISB_IOWR, 16'h311, 32'h3f);
      event_pulse <= 6'(1 << i);
      m_stat |= 1 << i;
      @(posedge pclk);
      event_pulse <= 6'h00;
      repeat (3) @(posedge pclk);
      chk("irqmsk", bus_if.irq, 0);
      m_mask = 32'h3f ^ (1 << i);
      io(ISB_IOWR, 16'h311, m_mask);
      chk("irq", bus_if.irq, 1);
      chk("hostirq", irq_out, 1);
      io(ISB_IORD, 16'h310, 0);
      chk("stat", r[5:0], m_stat);
      m_stat = 0;
      chk("irqclr", bus_if.irq, 0);
      apb(1'b0, HR_ISTAT, 0);
      chk("istat", r[1], 1);
    end
    io(ISB_IORD, 16'h311, 0);
    chk("mask", r[5:0], m_mask);
    tdone("irq");
    prom_data <= 8'($urandom);
    io(ISB_MEMRD, 16'h800, 0);
    chk("boot", r[7:0], prom_data);
    chk("bsel", n_bsel != 0, 1);
    chk("paddr", prom_addr, 32'h800);
    chk("bootwide", st[2], 0);
    chk("boothi", r[15:8], 0);
    k_sel = n_bsel;
    io(ISB_REFRD, 16'h800, 0);
    chk("refresh", r[7:0], 0);
    chk("refsel", n_bsel, k_sel);
    tdone("boot");
    // host-timed isa reset; wait covers the count and the syncing
    apb(1'b1, HR_CTRL, 1);
    repeat (2 * RESET_CYC) @(posedge pclk);
    io(ISB_IORD, 16'h3f0, 0);
    chk("rstwcfg", r[7:0], WCFG_RST);
    io(ISB_IORD, 16'h311, 0);
    chk("rstmask", r[5:0], MASK_RST);
    tdone("isareset");
    end_sim();
  end
endmodule : test_isa_slave_bus_interface
`default_nettype wire
